// file: src/dsw_device.sv
// converter end: shifts the serial frame on the link clock, decodes mode and code
// assumes link.sync_n low for at least three sys_clk_in cycles after the last bit
// Behaviour
// - shift one bit per falling serial clock edge
// - frame is 16 or 24 bits
// - mode bits before data, data msb first
// - 12-bit: skip two, mode 13:12, data 11:0
// - 14-bit: mode 15:14, data 13:0
// - 16-bit: skip six, mode 17:16, data 15:0
// - last edge loads registers, output updates
// - host keeps select high 20 ns between frames
// - serial clock idle level may be either
// - code is unipolar straight binary
// - mode 00 drives output from dac code
// - modes 01/10/11 select 1k, 100k, open
// - power-down keeps dac register unchanged
// - power-up clears registers, output zero
// - 2.5 us recovery after leaving power-down
// - early select rise aborts, registers unchanged
`timescale 1ns/1ns
module dsw_device #(
  parameter int RES = 16
) (
  dsw_if.dev                link,
  input  wire logic         sys_clk_in,
  input  wire logic         rst_in,
  input  wire logic         clk_en_in,
  output logic [RES-1:0]    analog_output_out,
  output logic              power_mode_hi_out,
  output logic              power_mode_lo_out,
  output logic              output_valid_out,
  output logic              frame_done_out
);

  localparam int FL = dsw_pkg::dsw_frame_len(RES);

  typedef enum logic [2:0] {
    DSW_ST_NORMAL = 3'h1,
    DSW_ST_PDOWN  = 3'h2,
    DSW_ST_WAKE   = 3'h4
  } dsw_state_e;

  typedef struct packed {
    logic [dsw_pkg::CNT_W-1:0] cnt;
    logic                      done;
    logic [FL-1:0]             shift;
  } dsw_lnk_s;

  typedef struct packed {
    logic                         done_s1;
    logic                         done_s2;
    logic                         done_d;
    dsw_state_e                   state;
    dsw_pkg::dsw_mode_e           mode;
    logic [RES-1:0]               code;
    logic [dsw_pkg::TIMER_W-1:0]  timer;
    logic [RES-1:0]               out_code;
    logic                         valid;
    logic                         pulse;
  } dsw_sys_s;

  dsw_lnk_s lnk_reg;
  dsw_lnk_s lnk_next;
  dsw_sys_s sys_reg;
  dsw_sys_s sys_next;

  // link side: the select line itself clears the frame, since the clock may stop
  always_comb
  begin
    lnk_next = lnk_reg;
    if (!lnk_reg.done)
    begin
      lnk_next.shift = {lnk_reg.shift[FL-2:0], link.din};
      if (lnk_reg.cnt == dsw_pkg::CNT_W'(FL - 1))
      begin
        lnk_next.done = 1'b1;
      end
      else
      begin
        lnk_next.cnt = lnk_reg.cnt + dsw_pkg::CNT_W'(1);
      end
    end
  end

  // a rise of the select before the last edge wipes the partial word
  always_ff @(negedge link.sclk or posedge link.sync_n)
  begin
    if (link.sync_n)
    begin
      lnk_reg <= '0;
    end
    else
    begin
      lnk_reg <= lnk_next;
    end
  end

  // system side: done level crosses by two flops; the word is frozen while done is high
  always_comb
  begin
    logic [1:0]     new_mode;
    logic [RES-1:0] new_code;
    new_mode = lnk_reg.shift[RES+1:RES];
    new_code = lnk_reg.shift[RES-1:0];
    sys_next = sys_reg;
    sys_next.done_s1 = lnk_reg.done;
    sys_next.done_s2 = sys_reg.done_s1;
    sys_next.done_d = sys_reg.done_s2;
    sys_next.pulse = 1'b0;
    case (sys_reg.state)
      DSW_ST_NORMAL:
      begin
        sys_next.state = DSW_ST_NORMAL;
      end
      DSW_ST_PDOWN:
      begin
        sys_next.state = DSW_ST_PDOWN;
      end
      DSW_ST_WAKE:
      begin
        if (sys_reg.timer == '0)
        begin
          sys_next.state = DSW_ST_NORMAL;
        end
        else
        begin
          sys_next.timer = sys_reg.timer - dsw_pkg::TIMER_W'(1);
        end
      end
      default:
      begin
        sys_next.state = DSW_ST_NORMAL;
      end
    endcase
    if (sys_reg.done_s2 && !sys_reg.done_d)
    begin
      sys_next.pulse = 1'b1;
      sys_next.mode = dsw_pkg::dsw_mode_e'(new_mode);
      if (new_mode == dsw_pkg::DSW_PM_NORMAL)
      begin
        sys_next.code = new_code;
        if (sys_reg.state == DSW_ST_NORMAL)
        begin
          sys_next.state = DSW_ST_NORMAL;
        end
        else
        begin
          sys_next.state = DSW_ST_WAKE;
          sys_next.timer = dsw_pkg::TIMER_W'(dsw_pkg::WAKE_CYC - 1);
        end
      end
      else
      begin
        sys_next.state = DSW_ST_PDOWN;
      end
    end
    // powered-down or waking amplifier shows zero, never a stale value
    sys_next.valid = (sys_next.state == DSW_ST_NORMAL);
    sys_next.out_code = sys_next.valid ? sys_next.code : '0;
  end

  always_ff @(posedge sys_clk_in)
  begin
    if (rst_in)
    begin
      sys_reg <= '{done_s1: 1'b0, done_s2: 1'b0, done_d: 1'b0, state: DSW_ST_NORMAL,
                   mode: dsw_pkg::DSW_PM_NORMAL, code: '0, timer: '0, out_code: '0,
                   valid: 1'b1, pulse: 1'b0};
    end
    else if (clk_en_in)
    begin
      sys_reg <= sys_next;
    end
  end

  assign analog_output_out = sys_reg.out_code;
  assign power_mode_hi_out = sys_reg.mode[1];
  assign power_mode_lo_out = sys_reg.mode[0];
  assign output_valid_out  = sys_reg.valid;
  assign frame_done_out    = sys_reg.pulse;

endmodule : dsw_device

// file: src/dsw_host.sv
// serial master end: builds the frame and drives the three link wires
// assumes write_in is only honoured while busy_out is low
`timescale 1ns/1ns
module dsw_host #(
  parameter int RES      = 16,
  parameter int HALF_DIV = dsw_pkg::HALF_DIV_DEF
) (
  dsw_if.host               link,
  input  wire logic         sys_clk_in,
  input  wire logic         rst_in,
  input  wire logic         clk_en_in,
  input  wire logic         write_in,
  input  wire logic         abort_in,
  input  wire logic         power_mode_hi_in,
  input  wire logic         power_mode_lo_in,
  input  wire logic [RES-1:0] code_in,
  output logic              busy_out,
  output logic              sent_out
);

  localparam int FL = dsw_pkg::dsw_frame_len(RES);

  typedef enum logic [3:0] {
    DSW_H_IDLE  = 4'h1,
    DSW_H_SHIFT = 4'h2,
    DSW_H_TAIL  = 4'h4,
    DSW_H_GAP   = 4'h8
  } dsw_hstate_e;

  typedef struct packed {
    dsw_hstate_e               state;
    logic [FL-1:0]             word;
    logic [dsw_pkg::CNT_W-1:0] cnt;
    logic [7:0]                div;
    logic                      sclk;
    logic                      sync_n;
    logic                      din;
    logic                      busy;
    logic                      sent;
  } dsw_host_s;

  dsw_host_s st_reg;
  dsw_host_s st_next;

  always_comb
  begin
    st_next = st_reg;
    st_next.sent = 1'b0;
    case (st_reg.state)
      DSW_H_IDLE:
      begin
        if (write_in)
        begin
          st_next.word = '0;
          st_next.word[RES+1:0] = {power_mode_hi_in, power_mode_lo_in, code_in};
          st_next.din = st_next.word[FL-1];
          st_next.sync_n = 1'b0;
          st_next.cnt = '0;
          st_next.div = 8'(HALF_DIV - 1);
          st_next.busy = 1'b1;
          st_next.state = DSW_H_SHIFT;
        end
      end
      DSW_H_SHIFT:
      begin
        if (abort_in)
        begin
          st_next.sync_n = 1'b1;
          st_next.sclk = 1'b1;
          st_next.div = 8'(dsw_pkg::SYNC_GAP_CYC - 1);
          st_next.state = DSW_H_GAP;
        end
        else if (st_reg.div != '0)
        begin
          st_next.div = st_reg.div - 8'h01;
        end
        else
        begin
          st_next.div = 8'(HALF_DIV - 1);
          st_next.sclk = ~st_reg.sclk;
          if (st_reg.sclk)
          begin
            if (st_reg.cnt == dsw_pkg::CNT_W'(FL - 1))
            begin
              st_next.state = DSW_H_TAIL;
            end
          end
          else
          begin
            // data moves on the rising edge so it is settled for the falling one
            st_next.word = {st_reg.word[FL-2:0], 1'b0};
            st_next.din = st_reg.word[FL-2];
            st_next.cnt = st_reg.cnt + dsw_pkg::CNT_W'(1);
          end
        end
      end
      DSW_H_TAIL:
      begin
        // select stays low a half period so the far end can see the finished frame
        if (st_reg.div != '0)
        begin
          st_next.div = st_reg.div - 8'h01;
        end
        else
        begin
          st_next.sync_n = 1'b1;
          st_next.sclk = 1'b1;
          st_next.sent = 1'b1;
          st_next.div = 8'(dsw_pkg::SYNC_GAP_CYC - 1);
          st_next.state = DSW_H_GAP;
        end
      end
      DSW_H_GAP:
      begin
        if (st_reg.div != '0)
        begin
          st_next.div = st_reg.div - 8'h01;
        end
        else
        begin
          st_next.busy = 1'b0;
          st_next.state = DSW_H_IDLE;
        end
      end
      default:
      begin
        st_next.state = DSW_H_IDLE;
      end
    endcase
  end

  always_ff @(posedge sys_clk_in)
  begin
    if (rst_in)
    begin
      st_reg <= '{state: DSW_H_IDLE, word: '0, cnt: '0, div: 8'h00, sclk: 1'b1,
                  sync_n: 1'b1, din: 1'b0, busy: 1'b0, sent: 1'b0};
    end
    else if (clk_en_in)
    begin
      st_reg <= st_next;
    end
  end

  assign link.sclk   = st_reg.sclk;
  assign link.sync_n = st_reg.sync_n;
  assign link.din    = st_reg.din;
  assign busy_out    = st_reg.busy;
  assign sent_out    = st_reg.sent;

endmodule : dsw_host

// file: src/dsw_if.sv
// three-wire link between the serial master and the converter
// assumes the master is the only driver; no bidirectional pins
`timescale 1ns/1ns
interface dsw_if;
  logic sclk;
  logic sync_n;
  logic din;

  modport host (output sclk, output sync_n, output din);
  modport dev  (input sclk, input sync_n, input din);
endinterface : dsw_if

// file: src/dsw_pkg.sv
// shared constants for the serial word loader: frame layout, power modes, timing
// assumes both ends are built with the same resolution parameter
package dsw_pkg;

  localparam int FRAME_SHORT   = 16;
  localparam int FRAME_LONG    = 24;
  localparam int MODE_BITS     = 2;
  localparam int CNT_W         = 5;
  localparam int SYS_PERIOD_NS = 4;
  localparam int SYNC_GAP_NS   = 20;
  localparam int SYNC_GAP_CYC  = (SYNC_GAP_NS + SYS_PERIOD_NS - 1) / SYS_PERIOD_NS;
  localparam int WAKE_NS       = 2500;
  localparam int WAKE_CYC      = (WAKE_NS + SYS_PERIOD_NS - 1) / SYS_PERIOD_NS;
  localparam int HALF_DIV_DEF  = 5;
  localparam int TIMER_W       = 10;

  typedef enum logic [1:0] {
    DSW_PM_NORMAL = 2'h0,
    DSW_PM_1K     = 2'h1,
    DSW_PM_100K   = 2'h2,
    DSW_PM_OPEN   = 2'h3
  } dsw_mode_e;

  // 16-bit frames for the 12/14-bit parts, 24-bit frames for the 16-bit part
  function automatic int dsw_frame_len(input int res);
    dsw_frame_len = (res == 16) ? FRAME_LONG : FRAME_SHORT;
  endfunction : dsw_frame_len

endpackage : dsw_pkg

// file: test/dsw_link_sva.sv
// checker for the three-wire link and the converter outputs
// assumes the bench top instantiates it beside the link interface
`timescale 1ns/1ns
module dsw_link_sva #(
  parameter int RES = 16,
  parameter int FL  = dsw_pkg::dsw_frame_len(RES)
) (
  input wire logic           sys_clk_in,
  input wire logic           rst_in,
  input wire logic           sclk,
  input wire logic           sync_n,
  input wire logic           din,
  input wire logic           frame_done_out,
  input wire logic           power_mode_hi_out,
  input wire logic           power_mode_lo_out,
  input wire logic           output_valid_out,
  input wire logic [RES-1:0] analog_output_out
);
  // falling serial edges seen in the current frame
  logic [4:0] cnt_reg;
  always_ff @(posedge sys_clk_in)
  begin
    if (sync_n)
      cnt_reg <= 5'h0;
    else if ($fell(sclk))
      cnt_reg <= cnt_reg + 5'h1;
  end
  default clocking @(posedge sys_clk_in);
  endclocking
  default disable iff (rst_in);
  a_sclk_in_frame: assert property ($fell(sclk) |-> !sync_n)
    else $error("serial clock fell outside a frame");
  a_din_held: assert property (!sclk && !$past(sclk) |-> $stable(din))
    else $error("data moved while serial clock low");
  a_bit_count: assert property (cnt_reg <= FL)
    else $error("too many serial edges in a frame");
  a_gap_hold: assert property ($rose(sync_n) |-> sync_n [*5])
    else $error("select gap too short");
  a_done_timing: assert property ($fell(sclk) && cnt_reg == FL - 1 |-> ##[2:6] frame_done_out)
    else $error("no completion after last edge");
  a_done_pulse: assert property (frame_done_out |=> !frame_done_out)
    else $error("completion pulse too long");
  a_abort_quiet: assert property ($rose(sync_n) && cnt_reg < FL |-> !frame_done_out [*8])
    else $error("aborted frame completed");
  a_pd_output: assert property ((power_mode_hi_out || power_mode_lo_out)
    |-> analog_output_out == '0 && !output_valid_out)
    else $error("output active in power-down");
  a_modes_hold: assert property ($changed({power_mode_hi_out, power_mode_lo_out})
    |-> frame_done_out)
    else $error("mode changed without a frame");
endmodule : dsw_link_sva

// file: test/dsw_tb.sv
// bench top: host and converter joined by the link, host user side driven here
// assumes package, interface and both ends are compiled first
`timescale 1ns/1ns
module dsw_tb;
  logic        sys_clk_in;
  logic        rst_in;
  logic        write_in;
  logic        abort_in;
  logic [1:0]  mode;
  logic [15:0] code;
  logic        busy_out;
  logic        sent_out;
  logic [15:0] analog_output_out;
  logic        power_mode_hi_out;
  logic        power_mode_lo_out;
  logic        output_valid_out;
  logic        frame_done_out;
  int          n_errors = 0;
  int          comparisons = 0;
  int          n_done = 0;
  int          n_sent = 0;
  logic        clk_en;
  logic        write12;
  logic        busy12;
  logic [11:0] out12;
  logic        hi12;
  logic        lo12;
  logic        valid12;
  dsw_if link ();
  dsw_if link12 ();
  dsw_host #(.RES(16)) dsw_host_inst (.link(link.host), .sys_clk_in(sys_clk_in),
    .rst_in(rst_in), .clk_en_in(clk_en), .write_in(write_in), .abort_in(abort_in),
    .power_mode_hi_in(mode[1]), .power_mode_lo_in(mode[0]), .code_in(code),
    .busy_out(busy_out), .sent_out(sent_out));
  dsw_device #(.RES(16)) dsw_device_inst (.link(link.dev), .sys_clk_in(sys_clk_in),
    .rst_in(rst_in), .clk_en_in(clk_en), .analog_output_out(analog_output_out),
    .power_mode_hi_out(power_mode_hi_out), .power_mode_lo_out(power_mode_lo_out),
    .output_valid_out(output_valid_out), .frame_done_out(frame_done_out));
  // short-frame pair shares mode, code and abort but has its own write; abort only acts while it shifts
  dsw_host #(.RES(12)) dsw_host_short_inst (.link(link12.host), .sys_clk_in(sys_clk_in),
    .rst_in(rst_in), .clk_en_in(clk_en), .write_in(write12), .abort_in(abort_in),
    .power_mode_hi_in(mode[1]), .power_mode_lo_in(mode[0]), .code_in(code[11:0]),
    .busy_out(busy12), .sent_out());
  dsw_device #(.RES(12)) dsw_device_short_inst (.link(link12.dev),
    .sys_clk_in(sys_clk_in), .rst_in(rst_in), .clk_en_in(clk_en),
    .analog_output_out(out12), .power_mode_hi_out(hi12), .power_mode_lo_out(lo12),
    .output_valid_out(valid12), .frame_done_out());
  dsw_link_sva #(.RES(16)) dsw_link_sva_inst (.sys_clk_in(sys_clk_in),
    .rst_in(rst_in), .sclk(link.sclk), .sync_n(link.sync_n), .din(link.din),
    .frame_done_out(frame_done_out), .power_mode_hi_out(power_mode_hi_out),
    .power_mode_lo_out(power_mode_lo_out), .output_valid_out(output_valid_out),
    .analog_output_out(analog_output_out));
  initial
  begin
    sys_clk_in = 1'b0;
    forever #2 sys_clk_in = ~sys_clk_in;
  end
  always @(posedge sys_clk_in)
  begin
    if (frame_done_out === 1'b1)
      n_done++;
    if (sent_out === 1'b1)
      n_sent++;
  end
  task automatic report_and_stop;
    $display("errors %0d comparisons %0d", n_errors, comparisons);
    if (n_errors == 0 && comparisons > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : report_and_stop
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      n_errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic st(input logic v, input logic [1:0] m, input logic [15:0] a);
    chk({output_valid_out, power_mode_hi_out, power_mode_lo_out, analog_output_out},
      {v, m, a});
  endtask : st
  // both hosts idle; a hung frame counts as a mismatch
  task automatic wait_idle;
    int i;
    i = 0;
    while ((busy_out !== 1'b0 || busy12 !== 1'b0) && i < 1000)
    begin
      @(posedge sys_clk_in) #1;
      i++;
    end
    if (i == 1000)
      n_errors++;
  endtask : wait_idle
  // ab > 0 raises abort that many cycles into the shift
  task automatic wr(input logic [1:0] m, input logic [15:0] c, input int ab);
    @(posedge sys_clk_in) #1;
    mode = m;
    code = c;
    write_in = 1'b1;
    @(posedge sys_clk_in) #1;
    write_in = 1'b0;
    if (ab > 0)
    begin
      repeat (ab) @(posedge sys_clk_in);
      #1 abort_in = 1'b1;
      @(posedge sys_clk_in) #1;
      abort_in = 1'b0;
    end
    wait_idle();
  endtask : wr
  task automatic wr12(input logic [1:0] m, input logic [11:0] c);
    @(posedge sys_clk_in) #1;
    mode = m;
    code = {4'hf, c};
    write12 = 1'b1;
    @(posedge sys_clk_in) #1;
    write12 = 1'b0;
    wait_idle();
  endtask : wr12
  // two frames back to back; patterns differ from their bit reversal
  task automatic s_normal;
    int d;
    int s;
    d = n_done;
    s = n_sent;
    wr(2'h0, 16'hc0a5, 0);
    st(1'b1, 2'h0, 16'hc0a5);
    wr(2'h0, 16'h1234, 0);
    st(1'b1, 2'h0, 16'h1234);
    chk(n_done - d, 2);
    chk(n_sent - s, 2);
  endtask : s_normal
  task automatic s_modes;
    for (int m = 1; m < 4; m++)
    begin
      wr(m[1:0], 16'h0f0f, 0);
      st(1'b0, m[1:0], 16'h0);
    end
  endtask : s_modes
  // output stays dark while the amplifier recovers
  task automatic s_wake;
    wr(2'h0, 16'h00f0, 0);
    st(1'b0, 2'h0, 16'h0);
    repeat (dsw_pkg::WAKE_CYC - 20) @(posedge sys_clk_in);
    #1 st(1'b0, 2'h0, 16'h0);
    repeat (20) @(posedge sys_clk_in);
    #1 st(1'b1, 2'h0, 16'h00f0);
  endtask : s_wake
  task automatic s_abort;
    int d;
    int s;
    d = n_done;
    s = n_sent;
    wr(2'h1, 16'h5a5a, 60);
    st(1'b1, 2'h0, 16'h00f0);
    chk(n_done - d, 0);
    chk(n_sent - s, 0);
    wr(2'h0, 16'h3c3c, 0);
    st(1'b1, 2'h0, 16'h3c3c);
  endtask : s_abort
  // enable low stalls both ends mid-frame; the frame must resume and land whole
  task automatic s_freeze;
    int d;
    d = n_done;
    @(posedge sys_clk_in) #1;
    mode = 2'h0;
    code = 16'h9bd1;
    write_in = 1'b1;
    @(posedge sys_clk_in) #1;
    write_in = 1'b0;
    repeat (30) @(posedge sys_clk_in);
    #1 clk_en = 1'b0;
    repeat (40) @(posedge sys_clk_in);
    #1 chk(busy_out, 1'b1);
    st(1'b1, 2'h0, 16'h3c3c);
    clk_en = 1'b1;
    wait_idle();
    st(1'b1, 2'h0, 16'h9bd1);
    chk(n_done - d, 1);
  endtask : s_freeze
  // mid-run reset brings both converters back to zero with the amplifier live
  task automatic s_reset;
    @(posedge sys_clk_in) #1;
    rst_in = 1'b1;
    repeat (10) @(posedge sys_clk_in);
    #1 rst_in = 1'b0;
    st(1'b1, 2'h0, 16'h0);
    chk({valid12, hi12, lo12, out12}, {1'b1, 2'h0, 12'h000});
  endtask : s_reset
  // short frame: mode bits sit right above a 12-bit code
  task automatic s_short;
    wr12(2'h0, 12'ha5c);
    chk({valid12, hi12, lo12, out12}, {1'b1, 2'h0, 12'ha5c});
    wr12(2'h2, 12'h3c1);
    chk({valid12, hi12, lo12, out12}, {1'b0, 2'h2, 12'h000});
    st(1'b1, 2'h0, 16'h0);
  endtask : s_short
  initial
  begin
    #100000;
    n_errors++;
    report_and_stop();
  end
  initial
  begin
    rst_in = 1'b1;
    clk_en = 1'b1;
    write_in = 1'b0;
    write12 = 1'b0;
    abort_in = 1'b0;
    mode = 2'h0;
    code = 16'h0;
    repeat (10) @(posedge sys_clk_in);
    #1 rst_in = 1'b0;
    st(1'b1, 2'h0, 16'h0);
    s_normal();
    s_modes();
    s_wake();
    s_abort();
    s_freeze();
    s_reset();
    s_short();
    report_and_stop();
  end
endmodule : dsw_tb
